/* i2cf_pkg.sv */
// Constants for the I2C interrupt status flag block.
// Assumes a 32-bit register port in the controller clock domain.
package i2cf_pkg;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [31:0] ADDR_MASKED_STAT = 32'h5000142c; // Masked view
   localparam logic [31:0] ADDR_INTR_MASK = 32'h50001430; // Mask
   localparam logic [31:0] ADDR_RAW_STAT = 32'h50001434; // Raw view
   localparam logic [31:0] ADDR_DATA_CMD = 32'h50001480; // Data port
   localparam logic [31:0] ADDR_TX_TL = 32'h50001484; // Tx threshold
   localparam logic [31:0] ADDR_RX_THRESHOLD_LEVEL = 32'h50001488; // Rx threshold
   localparam logic [31:0] ADDR_ENABLE = 32'h5000148c; // Enable bit 0
   localparam logic [31:0] ADDR_ABORT_CAUSE = 32'h50001490; // Abort cause
   localparam logic [31:0] ADDR_CLR_ALL = 32'h50001494; // Clear all
   localparam logic [31:0] ADDR_CLR_RX_UNDER = 32'h50001498;
   localparam logic [31:0] ADDR_CLR_RX_OVER = 32'h5000149c;
   localparam logic [31:0] ADDR_CLR_TX_OVER = 32'h500014a0;
   localparam logic [31:0] ADDR_CLR_RD_REQ = 32'h500014a4;
   localparam logic [31:0] ADDR_CLR_TX_ABORT = 32'h500014a8;
   localparam logic [31:0] ADDR_CLR_TX_DONE = 32'h500014ac;
   localparam logic [31:0] ADDR_CLR_ACTIVITY = 32'h500014b0;
   localparam logic [31:0] ADDR_CLR_STOP = 32'h500014b4;
   localparam logic [31:0] ADDR_CLR_START = 32'h500014b8;
   localparam logic [31:0] ADDR_CLR_GEN_CALL = 32'h500014bc;

   // ----------------------------------------------------------------
   // Status bit positions
   // ----------------------------------------------------------------
   localparam int BIT_RX_UNDER = 0;
   localparam int BIT_RX_OVER = 1;
   localparam int BIT_RX_FULL = 2;
   localparam int BIT_TX_OVER = 3;
   localparam int BIT_TX_EMPTY = 4;
   localparam int BIT_RD_REQ = 5;
   localparam int BIT_TX_ABORT = 6;
   localparam int BIT_TX_DONE = 7;
   localparam int BIT_ACTIVITY = 8;
   localparam int BIT_STOP = 9;
   localparam int BIT_START = 10;
   localparam int BIT_GEN_CALL = 11;
   localparam int BIT_ENABLE = 0;

   // ----------------------------------------------------------------
   // Widths and reset values
   // ----------------------------------------------------------------
   localparam int STAT_W = 16; // Status register width
   localparam int TL_W = 8; // Threshold register width
   localparam int FIFO_DEPTH = 32; // Entries per FIFO
   localparam logic [STAT_W-1:0] MASK_RST = 16'h08ff; // Mask reset
   localparam logic [STAT_W-1:0] STAT_RST = 16'h0000; // Status reset
   localparam logic [TL_W-1:0] TX_TL_RST = 8'h00; // Tx threshold reset
   localparam logic [TL_W-1:0] RX_THRESHOLD_LEVEL_RST = 8'h00; // Rx threshold reset
   // Sticky bits, i.e. all but the two level driven ones
   localparam logic [STAT_W-1:0] STICKY_BITS = 16'h0feb;

   // Internal enable states
   typedef enum logic [1:0] {
      EN_OFF = 2'b00, // Disabled and idle
      EN_ON = 2'b01, // Enabled
      EN_DRAIN = 2'b10 // Disabled, state machines still busy
   } i2cf_en_t;

endpackage : i2cf_pkg

/* i2cf_level_if.sv */
// Interface between the flag logic and a FIFO level tracker.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface i2cf_level_if #(
   parameter int LVL_W = 6
);
   logic push; // Add one entry
   logic pop; // Remove one entry
   logic flush; // Empty and hold empty
   logic [LVL_W-1:0] level; // Current entry count
   logic full; // Level at depth
   logic empty; // Level zero

   modport counter (input push, input pop, input flush,
      output level, output full, output empty);
   modport user (output push, output pop, output flush,
      input level, input full, input empty);
endinterface : i2cf_level_if

/* i2cf_level_counter.sv */
// FIFO occupancy tracker with flush.
// Assumes callers never push when full nor pop when empty.
`timescale 1ns/100ps
module i2cf_level_counter #(
   parameter int DEPTH = 32,
   parameter int LVL_W = 6
) (
   input wire logic clk,
   input wire logic rst,
   i2cf_level_if.counter lvl
);
   logic [LVL_W-1:0] level_ff; // Entry count
   localparam logic [LVL_W-1:0] DEPTH_V = LVL_W'(DEPTH); // Full mark

   // ----------------------------------------------------------------
   // Level counting
   // ----------------------------------------------------------------
   // Flush wins over any push or pop
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         level_ff <= '0;
      end else if (lvl.flush) begin
         level_ff <= '0;
      end else if (lvl.push && !lvl.pop) begin
         level_ff <= level_ff + LVL_W'(1);
      end else if (lvl.pop && !lvl.push) begin
         level_ff <= level_ff - LVL_W'(1);
      end
   end

   assign lvl.level = level_ff;
   assign lvl.full = (level_ff == DEPTH_V);
   assign lvl.empty = (level_ff == '0);
endmodule : i2cf_level_counter

/* i2cf_status_flags.sv */
// Interrupt status flags of an I2C controller, with APB register port.
// Assumes bus events arrive as one-cycle pulses from the state machines
// on the same clock; data bytes themselves travel outside this block.
`timescale 1ns/100ps
module i2cf_status_flags
   import i2cf_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH,
   parameter int CAUSE_W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic startSeen,
   input wire logic stopSeen,
   input wire logic busActivity,
   input wire logic slvTxNack,
   input wire logic txAbortEvt,
   input wire logic [CAUSE_W-1:0] abortCause,
   input wire logic readReqEvt,
   input wire logic genCallEvt,
   input wire logic rxByteIn,
   input wire logic txPop,
   input wire logic masterActive,
   input wire logic slaveActive,
   output logic sclHoldLow,
   output logic txFlushOut,
   output logic rxFlushOut,
   output logic internalEnable,
   output logic irq
);
   localparam int LVL_W = $clog2(DEPTH + 1); // Level counter width

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [STAT_W-1:0] sticky_ff; // Event flags
   logic [STAT_W-1:0] nxt_sticky; // Next event flags
   logic [STAT_W-1:0] setVec; // Events this cycle
   logic [STAT_W-1:0] clrVec; // Clears this cycle
   logic [STAT_W-1:0] mask_ff; // Interrupt mask
   logic [STAT_W-1:0] rawStat; // Raw status view
   logic [STAT_W-1:0] nxt_raw; // Next sticky flags with current level bits
   logic txEmpty_ff; // Level bit 4
   logic rxFull_ff; // Level bit 2
   logic [TL_W-1:0] txTl_ff; // Tx threshold
   logic [TL_W-1:0] rxTl_ff; // Rx threshold
   logic ctrlEnable_ff; // Software enable bit
   i2cf_en_t enState_ff; // Internal enable state
   i2cf_en_t nxt_enState; // Next enable state
   logic intEn_ff; // Internal enable output flop
   logic [CAUSE_W-1:0] cause_ff; // Abort cause
   logic [31:0] prdata_ff; // Read data
   logic pready_ff; // Access phase ready
   logic pslverr_ff; // Unmapped address error
   logic irq_ff; // Combined interrupt
   logic sclHold_ff; // Clock stretch request
   logic txHold_ff; // Tx FIFO held flushed
   logic rxHold_ff; // Rx FIFO held flushed
   logic setupPh; // Setup phase
   logic accessRd; // Read completing
   logic accessWr; // Write completing
   logic busBusy; // Either state machine active
   logic dataWr; // Processor writes data port
   logic dataRd; // Processor reads data port
   logic nxt_txHold; // Next tx hold
   logic nxt_ctrlEnable; // Next enable bit

   i2cf_level_if #(.LVL_W(LVL_W)) txLvl ();
   i2cf_level_if #(.LVL_W(LVL_W)) rxLvl ();

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // Bits cleared by a read of a clear register
   function automatic logic [STAT_W-1:0] clrMaskOf(input logic [31:0] a);
      logic [STAT_W-1:0] m;
      m = '0;
      case (a)
         ADDR_CLR_ALL: m = STICKY_BITS;
         ADDR_CLR_RX_UNDER: m[BIT_RX_UNDER] = 1'b1;
         ADDR_CLR_RX_OVER: m[BIT_RX_OVER] = 1'b1;
         ADDR_CLR_TX_OVER: m[BIT_TX_OVER] = 1'b1;
         ADDR_CLR_RD_REQ: m[BIT_RD_REQ] = 1'b1;
         ADDR_CLR_TX_ABORT: m[BIT_TX_ABORT] = 1'b1;
         ADDR_CLR_TX_DONE: m[BIT_TX_DONE] = 1'b1;
         ADDR_CLR_ACTIVITY: m[BIT_ACTIVITY] = 1'b1;
         ADDR_CLR_STOP: m[BIT_STOP] = 1'b1;
         ADDR_CLR_START: m[BIT_START] = 1'b1;
         ADDR_CLR_GEN_CALL: m[BIT_GEN_CALL] = 1'b1;
         default: m = '0;
      endcase
      return m;
   endfunction : clrMaskOf

   // True when the address is a clear register
   function automatic logic isClr(input logic [31:0] a);
      return (a >= ADDR_CLR_ALL) && (a <= ADDR_CLR_GEN_CALL)
         && (a[1:0] == 2'b00);
   endfunction : isClr

   // ----------------------------------------------------------------
   // Bus phase decode
   // ----------------------------------------------------------------
   assign setupPh = psel && !penable;
   assign accessRd = psel && penable && pready_ff && !pwrite;
   assign accessWr = psel && penable && pready_ff && pwrite;
   assign dataWr = accessWr && (paddr == ADDR_DATA_CMD);
   assign dataRd = accessRd && (paddr == ADDR_DATA_CMD);
   assign busBusy = masterActive || slaveActive;

   // ----------------------------------------------------------------
   // Level trackers
   // ----------------------------------------------------------------
   // Bytes written while flushed are dropped
   assign txLvl.push = dataWr && !txLvl.full && !txHold_ff;
   assign txLvl.pop = txPop && !txLvl.empty;
   assign txLvl.flush = txHold_ff;
   // Byte into a full FIFO is acknowledged but lost
   assign rxLvl.push = rxByteIn && !rxLvl.full && !rxHold_ff;
   assign rxLvl.pop = dataRd && !rxLvl.empty;
   assign rxLvl.flush = rxHold_ff;

   i2cf_level_counter #(.DEPTH(DEPTH), .LVL_W(LVL_W)) txCount (
      .clk(clk),
      .rst(rst),
      .lvl(txLvl.counter)
   );

   i2cf_level_counter #(.DEPTH(DEPTH), .LVL_W(LVL_W)) rxCount (
      .clk(clk),
      .rst(rst),
      .lvl(rxLvl.counter)
   );

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   // Enable, thresholds and mask; written in the access phase
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrlEnable_ff <= 1'b0;
         txTl_ff <= TX_TL_RST;
         rxTl_ff <= RX_THRESHOLD_LEVEL_RST;
         mask_ff <= MASK_RST;
      end else if (accessWr) begin
         case (paddr)
            ADDR_ENABLE: ctrlEnable_ff <= pwdata[BIT_ENABLE];
            ADDR_TX_TL: txTl_ff <= pwdata[TL_W-1:0];
            ADDR_RX_THRESHOLD_LEVEL: rxTl_ff <= pwdata[TL_W-1:0];
            ADDR_INTR_MASK: mask_ff <= pwdata[STAT_W-1:0] & STICKY_MASK();
            default: ; // Other addresses hold
         endcase
      end
   end

   // Valid mask bits, reserved ones read as zero
   function automatic logic [STAT_W-1:0] STICKY_MASK();
      return 16'h0fff;
   endfunction : STICKY_MASK

   assign nxt_ctrlEnable = (accessWr && paddr == ADDR_ENABLE) ?
      pwdata[BIT_ENABLE] : ctrlEnable_ff;

   // ----------------------------------------------------------------
   // Internal enable state machine
   // ----------------------------------------------------------------
   // Internal enable falls only once both state machines are idle
   always_comb begin
      nxt_enState = enState_ff;
      case (enState_ff)
         EN_OFF: if (ctrlEnable_ff) nxt_enState = EN_ON;
         EN_ON: begin
            if (!ctrlEnable_ff) begin
               nxt_enState = busBusy ? EN_DRAIN : EN_OFF;
            end
         end
         EN_DRAIN: begin
            if (ctrlEnable_ff) begin
               nxt_enState = EN_ON;
            end else if (!busBusy) begin
               nxt_enState = EN_OFF;
            end
         end
         default: nxt_enState = EN_OFF;
      endcase
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         enState_ff <= EN_OFF;
         intEn_ff <= 1'b0;
      end else begin
         enState_ff <= nxt_enState;
         intEn_ff <= (nxt_enState != EN_OFF);
      end
   end

   // ----------------------------------------------------------------
   // Sticky event flags
   // ----------------------------------------------------------------
   // Set vector from events, clear vector from reads and disable
   always_comb begin
      setVec = '0;
      setVec[BIT_START] = startSeen;
      setVec[BIT_STOP] = stopSeen;
      setVec[BIT_ACTIVITY] = busActivity;
      setVec[BIT_TX_DONE] = slvTxNack;
      setVec[BIT_TX_ABORT] = txAbortEvt;
      setVec[BIT_RD_REQ] = readReqEvt;
      setVec[BIT_GEN_CALL] = genCallEvt;
      setVec[BIT_TX_OVER] = dataWr && txLvl.full;
      setVec[BIT_RX_OVER] = rxByteIn && rxLvl.full;
      setVec[BIT_RX_UNDER] = dataRd && rxLvl.empty;
      clrVec = accessRd ? clrMaskOf(paddr) : '0;
      if (enState_ff == EN_OFF) begin
         // Disabled and idle: enable-dependent flags drop
         clrVec[BIT_ACTIVITY] = 1'b1;
         clrVec[BIT_GEN_CALL] = 1'b1;
         clrVec[BIT_TX_OVER] = 1'b1;
         clrVec[BIT_RX_OVER] = 1'b1;
         clrVec[BIT_RX_UNDER] = 1'b1;
      end
      // A new event wins over a clear in the same cycle
      nxt_sticky = ((sticky_ff & ~clrVec) | setVec) & STICKY_BITS;
   end

   // Flag register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sticky_ff <= STAT_RST;
      end else begin
         sticky_ff <= nxt_sticky;
      end
   end

   // Cause of the last abort, cleared with the abort flag
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cause_ff <= '0;
      end else if (txAbortEvt) begin
         cause_ff <= abortCause;
      end else if (clrVec[BIT_TX_ABORT]) begin
         cause_ff <= '0;
      end
   end

   // ----------------------------------------------------------------
   // Level driven flags and FIFO holds
   // ----------------------------------------------------------------
   assign nxt_txHold = !nxt_ctrlEnable || nxt_sticky[BIT_TX_ABORT];

   // Thresholds compare against the live levels
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txEmpty_ff <= 1'b0;
         rxFull_ff <= 1'b0;
         txHold_ff <= 1'b1;
         rxHold_ff <= 1'b1;
      end else begin
         if (ctrlEnable_ff) begin
            txEmpty_ff <= (TL_W'(txLvl.level) <= txTl_ff);
         end else begin
            txEmpty_ff <= busBusy;
         end
         rxFull_ff <= nxt_ctrlEnable
            && (TL_W'(rxLvl.level) >= rxTl_ff);
         txHold_ff <= nxt_txHold;
         rxHold_ff <= !nxt_ctrlEnable;
      end
   end

   // ----------------------------------------------------------------
   // Status views and outputs
   // ----------------------------------------------------------------
   always_comb begin
      rawStat = sticky_ff;
      rawStat[BIT_TX_EMPTY] = txEmpty_ff;
      rawStat[BIT_RX_FULL] = rxFull_ff;
      nxt_raw = nxt_sticky;
      nxt_raw[BIT_TX_EMPTY] = txEmpty_ff;
      nxt_raw[BIT_RX_FULL] = rxFull_ff;
   end

   // Interrupt, stretch and hold outputs from flops
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_ff <= 1'b0;
         sclHold_ff <= 1'b0;
      end else begin
         irq_ff <= |(nxt_raw & mask_ff);
         sclHold_ff <= nxt_sticky[BIT_RD_REQ];
      end
   end

   // ----------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------
   // Read data and error captured in the setup phase
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata_ff <= '0;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= setupPh;
         if (setupPh) begin
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
            case (paddr)
               ADDR_MASKED_STAT: prdata_ff[STAT_W-1:0] <=
                  rawStat & mask_ff;
               ADDR_INTR_MASK: prdata_ff[STAT_W-1:0] <= mask_ff;
               ADDR_RAW_STAT: prdata_ff[STAT_W-1:0] <= rawStat;
               ADDR_DATA_CMD: prdata_ff <= '0;
               ADDR_TX_TL: prdata_ff[TL_W-1:0] <= txTl_ff;
               ADDR_RX_THRESHOLD_LEVEL: prdata_ff[TL_W-1:0] <= rxTl_ff;
               ADDR_ENABLE: prdata_ff[BIT_ENABLE] <= ctrlEnable_ff;
               ADDR_ABORT_CAUSE: prdata_ff[CAUSE_W-1:0] <= cause_ff;
               default: pslverr_ff <= !isClr(paddr);
            endcase
         end
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign irq = irq_ff;
   assign sclHoldLow = sclHold_ff;
   assign txFlushOut = txHold_ff;
   assign rxFlushOut = rxHold_ff;
   assign internalEnable = intEn_ff;
endmodule : i2cf_status_flags

/* i2cf_status_monitor.sv */
// Checker for the status flag block, bound onto its top module.
// Assumes one controller clock and asynchronous active-high reset.
`timescale 1ns/100ps
module i2cf_status_monitor
   import i2cf_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic readReqEvt,
   input wire logic txAbortEvt,
   input wire logic masterActive,
   input wire logic slaveActive,
   input wire logic sclHoldLow,
   input wire logic txFlushOut,
   input wire logic rxFlushOut,
   input wire logic internalEnable
);
   // ---------------------------------------------------------------
   // Access decoding
   // ---------------------------------------------------------------
   logic acc, rdClr, abClr, enWr; // Completed access kinds
   assign acc = psel && penable && pready;
   assign rdClr = acc && !pwrite
      && (paddr == ADDR_CLR_RD_REQ || paddr == ADDR_CLR_ALL);
   assign abClr = acc && !pwrite
      && (paddr == ADDR_CLR_TX_ABORT || paddr == ADDR_CLR_ALL);
   assign enWr = acc && pwrite && paddr == ADDR_ENABLE;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   a_rdreq_stall: assert property (readReqEvt |=> sclHoldLow)
      else $error("read request did not stall the clock");
   a_stall_holds: assert property (sclHoldLow && !rdClr
      |=> sclHoldLow)
      else $error("clock stall ended without a clear");
   a_stall_release: assert property (rdClr && !readReqEvt
      |=> !sclHoldLow)
      else $error("clock stall not released by clear read");
   a_abort_flush: assert property (txAbortEvt |=> txFlushOut)
      else $error("abort did not flush the tx buffer");
   a_flush_holds: assert property (txFlushOut && internalEnable
      && !abClr && !enWr |=> txFlushOut)
      else $error("tx flush ended without an abort clear");
   a_disable_flush: assert property (enWr && !pwdata[0]
      |=> rxFlushOut && txFlushOut)
      else $error("disable did not flush both buffers");
   a_drain_hold: assert property (internalEnable
      && (masterActive || slaveActive) |=> internalEnable)
      else $error("internal enable fell while engines busy");
   a_idle_fall: assert property ($fell(internalEnable)
      |-> !$past(masterActive) && !$past(slaveActive))
      else $error("internal enable fell before engines idle");
endmodule : i2cf_status_monitor

bind i2cf_status_flags i2cf_status_monitor u_i2cf_status_monitor (
   .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .readReqEvt, .txAbortEvt, .masterActive, .slaveActive, .sclHoldLow,
   .txFlushOut, .rxFlushOut, .internalEnable);

/* i2cf_bus_model.sv */
// Behavioural far side: remote I2C parties seen as event pulses.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/100ps
module i2cf_bus_model (
   input wire logic clk,
   output logic startSeen,
   output logic stopSeen,
   output logic busActivity,
   output logic slvTxNack,
   output logic txAbortEvt,
   output logic readReqEvt,
   output logic genCallEvt,
   output logic rxByteIn,
   output logic txPop,
   output logic [15:0] abortCause,
   output logic masterActive,
   output logic slaveActive
);
   logic [8:0] pulse; // One bit per event kind
   // Event fan-out, index order matches the bench rows
   assign {txPop, rxByteIn, genCallEvt, readReqEvt, txAbortEvt,
      slvTxNack, busActivity, stopSeen, startSeen} = pulse;
   initial begin
      pulse = '0;
      abortCause = '0;
      masterActive = 1'b0;
      slaveActive = 1'b0;
   end
   // One-cycle pulse of event k; cause only valid with it
   task automatic fire(input int k);
      @(posedge clk);
      pulse[k] <= 1'b1;
      abortCause <= 16'h0a5c;
      @(posedge clk);
      pulse <= '0;
      abortCause <= 16'hf5a3;
   endtask : fire
   // Engine busy levels
   task automatic busy(input logic m, input logic s);
      @(posedge clk);
      masterActive <= m;
      slaveActive <= s;
   endtask : busy
endmodule : i2cf_bus_model

/* tb.sv */
// Self-checking bench for the I2C status flag block.
// Assumes the bus model drives every bus-side event input.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
   n_mismatch++; $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
   end end
module tb
   import i2cf_pkg::*;
();
   logic clk, rst, psel, penable, pwrite; // Clock, reset, bus controls
   logic [31:0] paddr, pwdata, prdata, q, m; // Bus data, read, mask
   logic pready, pslverr, e, sclHoldLow, txFlushOut, rxFlushOut;
   logic internalEnable, irq, startSeen, stopSeen, busActivity;
   logic slvTxNack, txAbortEvt, readReqEvt, genCallEvt, rxByteIn, txPop;
   logic masterActive, slaveActive; // Engine busy levels
   logic [15:0] abortCause; // Abort cause from the bus side
   int checks, n_mismatch; // Comparison and mismatch counts
   typedef struct {int k; int b; logic [31:0] clr;} i2cf_row_t;
   // Event kind, status bit, clear register
   i2cf_row_t rows[7] = '{
      '{0, BIT_START, ADDR_CLR_START},
      '{1, BIT_STOP, ADDR_CLR_STOP},
      '{2, BIT_ACTIVITY, ADDR_CLR_ACTIVITY},
      '{3, BIT_TX_DONE, ADDR_CLR_TX_DONE},
      '{4, BIT_TX_ABORT, ADDR_CLR_TX_ABORT},
      '{5, BIT_RD_REQ, ADDR_CLR_RD_REQ},
      '{6, BIT_GEN_CALL, ADDR_CLR_GEN_CALL}};

   i2cf_status_flags u_i2cf_status_flags (.clk, .rst, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .startSeen,
      .stopSeen, .busActivity, .slvTxNack, .txAbortEvt, .abortCause,
      .readReqEvt, .genCallEvt, .rxByteIn, .txPop, .masterActive,
      .slaveActive, .sclHoldLow, .txFlushOut, .rxFlushOut,
      .internalEnable, .irq);
   i2cf_bus_model u_i2cf_bus_model (.clk, .startSeen, .stopSeen,
      .busActivity, .slvTxNack, .txAbortEvt, .readReqEvt, .genCallEvt,
      .rxByteIn, .txPop, .abortCause, .masterActive, .slaveActive);

   always #50 clk = ~clk; // 10 MHz clock

   // One register access, setup then access phase
   task automatic apb(input logic wr, input logic [31:0] a, d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 8);
      if (pready !== 1'b1) n_mismatch++; // Handshake limit ran out
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic raw();
      apb(1'b0, ADDR_RAW_STAT, 32'h0);
   endtask : raw
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run

   // Watchdog against a hung handshake
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      complete_run();
   end

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      checks = 0;
      n_mismatch = 0;
      repeat (4) @(posedge clk);
      `CHK("reset flush", 2'b11, {txFlushOut, rxFlushOut})
      `CHK("reset enable", 2'b00, {internalEnable, irq})
      rst <= 1'b0;
      apb(1'b0, ADDR_INTR_MASK, 32'h0);
      `CHK("mask reset", {16'h0, MASK_RST}, q)
      raw();
      `CHK("raw reset", 32'h0, q)
      apb(1'b0, 32'h50001500, 32'h0);
      `CHK("unmapped error", 1'b1, e)
      apb(1'b1, ADDR_ENABLE, 32'h1);
      $display("reset test done");
      // Bus-event sticky flags, one row each
      foreach (rows[i]) begin
         m = 32'h1 << rows[i].b;
         apb(1'b1, ADDR_INTR_MASK, m);
         u_i2cf_bus_model.fire(rows[i].k);
         raw();
         `CHK("flag set", 1'b1, q[rows[i].b])
         apb(1'b0, ADDR_MASKED_STAT, 32'h0);
         `CHK("masked status", m, q)
         `CHK("irq set", 1'b1, irq)
         apb(1'b0, rows[i].clr, 32'h0);
         raw();
         `CHK("flag cleared", 1'b0, q[rows[i].b])
         `CHK("irq cleared", 1'b0, irq)
         $display("row %0d done", i);
      end
      // Read request stall and abort flush together
      u_i2cf_bus_model.fire(5);
      u_i2cf_bus_model.fire(4);
      apb(1'b0, ADDR_ABORT_CAUSE, 32'h0);
      `CHK("abort cause", 32'h0a5c, q)
      `CHK("stall", 1'b1, sclHoldLow)
      `CHK("tx flush", 1'b1, txFlushOut)
      apb(1'b1, ADDR_DATA_CMD, 32'h0);
      raw();
      `CHK("push dropped", 1'b1, q[BIT_TX_EMPTY])
      apb(1'b0, ADDR_CLR_RD_REQ, 32'h0);
      apb(1'b0, ADDR_CLR_TX_ABORT, 32'h0);
      raw();
      `CHK("stall released", 1'b0, sclHoldLow)
      `CHK("flush released", 1'b0, txFlushOut)
      $display("abort test done");
      // Tx buffer filled past depth
      repeat (FIFO_DEPTH) apb(1'b1, ADDR_DATA_CMD, 32'h0);
      raw();
      `CHK("tx full", 2'b00, {q[BIT_TX_OVER], q[BIT_TX_EMPTY]})
      apb(1'b1, ADDR_TX_TL, 32'h20);
      apb(1'b1, ADDR_DATA_CMD, 32'h0);
      raw();
      `CHK("tx over", 2'b11, {q[BIT_TX_OVER], q[BIT_TX_EMPTY]})
      u_i2cf_bus_model.fire(2);
      apb(1'b0, ADDR_CLR_ALL, 32'h0);
      raw();
      `CHK("clear all", 2'b00, {q[BIT_ACTIVITY], q[BIT_TX_OVER]})
      apb(1'b1, ADDR_DATA_CMD, 32'h0);
      apb(1'b1, ADDR_TX_TL, 32'h1f);
      raw();
      `CHK("tx above", 1'b0, q[BIT_TX_EMPTY])
      u_i2cf_bus_model.fire(8);
      raw();
      `CHK("tx popped", 1'b1, q[BIT_TX_EMPTY])
      $display("tx test done");
      // Rx threshold, overflow and underflow
      apb(1'b1, ADDR_RX_THRESHOLD_LEVEL, 32'h2);
      u_i2cf_bus_model.fire(7);
      raw();
      `CHK("rx below", 1'b0, q[BIT_RX_FULL])
      repeat (FIFO_DEPTH - 1) u_i2cf_bus_model.fire(7);
      raw();
      `CHK("rx at depth", 2'b10, {q[BIT_RX_FULL], q[BIT_RX_OVER]})
      u_i2cf_bus_model.fire(7);
      raw();
      `CHK("rx over", 1'b1, q[BIT_RX_OVER])
      repeat (FIFO_DEPTH - 1) apb(1'b0, ADDR_DATA_CMD, 32'h0);
      raw();
      `CHK("rx one", 2'b00, {q[BIT_RX_FULL], q[BIT_RX_UNDER]})
      repeat (2) apb(1'b0, ADDR_DATA_CMD, 32'h0);
      raw();
      `CHK("rx under", 1'b1, q[BIT_RX_UNDER])
      $display("rx test done");
      // Disable while the master engine is still busy
      repeat (2) u_i2cf_bus_model.fire(7);
      u_i2cf_bus_model.fire(2);
      u_i2cf_bus_model.fire(6);
      u_i2cf_bus_model.busy(1'b1, 1'b0);
      apb(1'b1, ADDR_ENABLE, 32'h0);
      raw();
      `CHK("drain status", 32'h091b, q)
      `CHK("drain", 2'b11, {internalEnable, rxFlushOut})
      u_i2cf_bus_model.busy(1'b0, 1'b1);
      raw();
      `CHK("slave busy", 2'b11, {internalEnable, q[BIT_TX_EMPTY]})
      u_i2cf_bus_model.busy(1'b0, 1'b0);
      repeat (3) @(posedge clk);
      raw();
      `CHK("idle status", 32'h0, q)
      `CHK("idle enable", 1'b0, internalEnable)
      $display("disable test done");
      complete_run();
   end
endmodule : tb
